// file: verilog/fspc_ctrl.v
// Flash self-programming register file and operation sequencer
`timescale 1ns/10ps
`include "fspc_consts.vh"
// Contract
// - 14-bit address: low register bits 7-0, high register 13-8, top two zero
// - Writing word0 low byte only updates that register, never the buffer
// - Writing word0 high byte loads the full 16-bit word into buffer; code loads it only while erase/write is enabled
// - Each such load increments the low address register only, visible on readback
// - Words 1 to 3 hold 16-bit values; all data and address reset zero
// - Enable status set by hardware only; software one ignored, zero disables
// - Mode 000 write, 001 erase, 011 read, 110 unlock; others reserved
// - Unlock trigger starts a procedure timer; hardware clears it at expiry
// - Unlock succeeds only with pattern 00,0D,C3,04,09,40 in words 1-3
// - Write-initiate starts write or erase; hardware clears it on completion
// - Reads blocked unless read-enable is high
// - Read-initiate starts a read; hardware clears it on completion
// - Core is stalled while a started read, write or erase runs
// - Writing 55h to chip reset register resets the whole chip
// - Time select 0: erase 3.2ms write 2.2ms; 1: 3.7ms and 3.0ms
// - Buffer-clear bit clears the page buffer; hardware clears bit at end
// - Auto-increment stops when low five address bits reach 11111b
// - Write buffer cleared automatically after a write completes
module fspc_ctrl #(
    parameter ERASE0_TICKS = `FSPC_ERASE0_US * `FSPC_SUB_KHZ / 1000,
    parameter WRITE0_TICKS = `FSPC_WRITE0_US * `FSPC_SUB_KHZ / 1000,
    parameter ERASE1_TICKS = `FSPC_ERASE1_US * `FSPC_SUB_KHZ / 1000,
    parameter WRITE1_TICKS = `FSPC_WRITE1_US * `FSPC_SUB_KHZ / 1000,
    parameter UNLOCK_TICKS = `FSPC_UNLOCK_TICKS,
    parameter READ_CYCLES  = `FSPC_READ_CYCLES
) (
    input  wire        ref_clk,
    input  wire        reset,
    input  wire        clk_en,
    input  wire        sub_clk,
    input  wire [3:0]  reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    output wire        core_stall,
    output reg         chip_reset,
    output reg         flash_erase,
    output reg         flash_write,
    output reg         flash_read,
    output reg  [13:0] flash_word_address,
    input  wire [15:0] flash_rdata,
    output reg  [15:0] read_word,
    input  wire [4:0]  buf_rd_addr,
    output wire [15:0] buf_rd_data
);
    localparam ST_IDLE  = 2'h0;
    localparam ST_PROG  = 2'h1;
    localparam ST_READ  = 2'h2;
    localparam ST_CLEAR = 2'h3;

    reg  [7:0]  addr_low;
    reg  [5:0]  addr_high;
    reg  [7:0]  w0l;
    reg  [7:0]  w0h;
    reg  [7:0]  w1l;
    reg  [7:0]  w1h;
    reg  [7:0]  w2l;
    reg  [7:0]  w2h;
    reg  [7:0]  w3l;
    reg  [7:0]  w3h;
    reg         erase_write_enabled_status;
    reg  [2:0]  operation_mode_select;
    reg         unlock_trigger;
    reg         write_initiate;
    reg         read_enable;
    reg         read_initiate;
    reg  [7:0]  chip_reset_trigger;
    reg         program_time_select;
    reg         buffer_clear_initiate;
    reg  [1:0]  state;
    reg  [15:0] op_count;
    reg  [7:0]  unlock_count;
    reg  [4:0]  clr_addr;
    reg  [7:0]  next_rdata;
    wire        sub_level;
    wire        sub_tick;
    wire        wr_any;
    wire [13:0] addr_full;
    wire        buf_load;
    wire        key_ok;
    wire [15:0] prog_ticks;

    // Decode a write strobe to one register
    function wr_hit;
        input       strobe;
        input [3:0] addr;
        input [3:0] target;
        begin
            wr_hit = strobe & (addr == target);
        end
    endfunction

    // Low-speed clock comes from another domain; rising edges counted as ticks
    fspc_sync u_sub (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .async_in (sub_clk),
        .level    (sub_level),
        .rise     (sub_tick)
    );

    assign wr_any    = reg_wr & clk_en;
    assign addr_full = {addr_high, addr_low};
    // Buffer takes words only once erase/write is enabled
    assign buf_load  = wr_hit(wr_any, reg_addr, `FSPC_W0_HIGH)
                       & erase_write_enabled_status;
    assign key_ok = (w1l == `FSPC_KEY_W1L) && (w1h == `FSPC_KEY_W1H) &&
                    (w2l == `FSPC_KEY_W2L) && (w2h == `FSPC_KEY_W2H) &&
                    (w3l == `FSPC_KEY_W3L) && (w3h == `FSPC_KEY_W3H);
    assign prog_ticks = (operation_mode_select == `FSPC_MODE_ERASE) ?
        (program_time_select ? ERASE1_TICKS[15:0] : ERASE0_TICKS[15:0]) :
        (program_time_select ? WRITE1_TICKS[15:0] : WRITE0_TICKS[15:0]);
    // above: durations selected by time select bit

    // The stall covers only operations that actually started
    assign core_stall = (state == ST_PROG) || (state == ST_READ);

    fspc_wbuf #(
        .DEPTH (`FSPC_PAGE_WORDS),
        .AW    (5),
        .DW    (16)
    ) u_buf (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .clk_en   (clk_en),
        .wr_en    (buf_load),
        .wr_addr  (addr_low[4:0]),
        .wr_data  ({reg_wdata, w0l}),
        .clr_en   (state == ST_CLEAR),
        .clr_addr (clr_addr),
        .rd_addr  (buf_rd_addr),
        .rd_data  (buf_rd_data)
    );

    // Address and data registers; high byte write lands in same cycle load
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            addr_low  <= 8'h00;
            addr_high <= 6'h00;
            w0l <= 8'h00;
            w0h <= 8'h00;
            w1l <= 8'h00;
            w1h <= 8'h00;
            w2l <= 8'h00;
            w2h <= 8'h00;
            w3l <= 8'h00;
            w3h <= 8'h00;
        end
        else if (clk_en)
        begin
            if (wr_hit(wr_any, reg_addr, `FSPC_ADDR_LOW))
                addr_low <= reg_wdata;
            if (wr_hit(wr_any, reg_addr, `FSPC_ADDR_HIGH))
                addr_high <= reg_wdata[5:0];
            if (wr_hit(wr_any, reg_addr, `FSPC_W0_LOW))
                w0l <= reg_wdata;
            if (wr_hit(wr_any, reg_addr, `FSPC_W0_HIGH))
                w0h <= reg_wdata;
            // Increment saturates at the page's last word
            if (buf_load && addr_low[4:0] != 5'h1f)
                addr_low <= addr_low + 8'h01;
            if (wr_hit(wr_any, reg_addr, `FSPC_W1_LOW))
                w1l <= reg_wdata;
            if (wr_hit(wr_any, reg_addr, `FSPC_W1_HIGH))
                w1h <= reg_wdata;
            if (wr_hit(wr_any, reg_addr, `FSPC_W2_LOW))
                w2l <= reg_wdata;
            if (wr_hit(wr_any, reg_addr, `FSPC_W2_HIGH))
                w2h <= reg_wdata;
            if (wr_hit(wr_any, reg_addr, `FSPC_W3_LOW))
                w3l <= reg_wdata;
            if (wr_hit(wr_any, reg_addr, `FSPC_W3_HIGH))
                w3h <= reg_wdata;
        end
    end

    // Unlock procedure: timer runs on low-speed ticks, key checked each cycle
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            unlock_trigger             <= 1'b0;
            unlock_count               <= 8'h00;
            erase_write_enabled_status <= 1'b0;
        end
        else if (clk_en)
        begin
            if (unlock_trigger)
            begin
                if (key_ok && operation_mode_select == `FSPC_MODE_UNLOCK)
                    erase_write_enabled_status <= 1'b1;
                if (sub_tick)
                    unlock_count <= unlock_count + 8'h01;
                if (sub_tick && unlock_count == UNLOCK_TICKS[7:0] - 8'h01)
                    unlock_trigger <= 1'b0;
            end
            else if (wr_hit(wr_any, reg_addr, `FSPC_MAIN_CTRL) &&
                     reg_wdata[`FSPC_UNLOCK_BIT])
            begin
                unlock_trigger <= 1'b1;
                unlock_count   <= 8'h00;
            end
            // Software may clear only; a one written is ignored
            if (wr_hit(wr_any, reg_addr, `FSPC_MAIN_CTRL) &&
                !reg_wdata[`FSPC_EN_BIT] &&
                !(unlock_trigger && key_ok &&
                  operation_mode_select == `FSPC_MODE_UNLOCK))
                erase_write_enabled_status <= 1'b0;
        end
    end

    // Control bits and the operation sequencer
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            operation_mode_select <= 3'h0;
            write_initiate        <= 1'b0;
            read_enable           <= 1'b0;
            read_initiate         <= 1'b0;
            program_time_select   <= 1'b0;
            buffer_clear_initiate <= 1'b0;
            chip_reset_trigger    <= 8'h00;
            chip_reset            <= 1'b0;
            state                 <= ST_IDLE;
            op_count              <= 16'h0000;
            clr_addr              <= 5'h00;
            flash_erase           <= 1'b0;
            flash_write           <= 1'b0;
            flash_read            <= 1'b0;
            flash_word_address    <= 14'h0000;
            read_word             <= 16'h0000;
        end
        else if (clk_en)
        begin
            chip_reset <= 1'b0;
            if (wr_hit(wr_any, reg_addr, `FSPC_CHIP_RST))
            begin
                chip_reset_trigger <= reg_wdata;
                chip_reset <= (reg_wdata == `FSPC_RESET_KEY);
            end
            if (wr_hit(wr_any, reg_addr, `FSPC_TIME_BUF))
                program_time_select <= reg_wdata[`FSPC_TSEL_BIT];
            if (wr_hit(wr_any, reg_addr, `FSPC_MAIN_CTRL) && state == ST_IDLE)
            begin
                operation_mode_select <= reg_wdata[`FSPC_MODE_HI:`FSPC_MODE_LO];
                read_enable <= reg_wdata[`FSPC_RDEN_BIT];
            end
            case (state)
                ST_IDLE:
                begin
                    // Start an operation from a control write, priority clear
                    if (wr_hit(wr_any, reg_addr, `FSPC_TIME_BUF) &&
                        reg_wdata[`FSPC_CLR_BIT])
                    begin
                        buffer_clear_initiate <= 1'b1;
                        clr_addr <= 5'h00;
                        state    <= ST_CLEAR;
                    end
                    else if (wr_hit(wr_any, reg_addr, `FSPC_MAIN_CTRL) &&
                             reg_wdata[`FSPC_WRITE_BIT] &&
                             erase_write_enabled_status &&
                             (reg_wdata[`FSPC_MODE_HI:`FSPC_MODE_LO] ==
                              `FSPC_MODE_WRITE ||
                              reg_wdata[`FSPC_MODE_HI:`FSPC_MODE_LO] ==
                              `FSPC_MODE_ERASE))
                    begin
                        write_initiate <= 1'b1;
                        flash_erase <= reg_wdata[`FSPC_MODE_LO];
                        flash_write <= ~reg_wdata[`FSPC_MODE_LO];
                        flash_word_address <= addr_full;
                        op_count <= 16'h0000;
                        state    <= ST_PROG;
                    end
                    else if (wr_hit(wr_any, reg_addr, `FSPC_MAIN_CTRL) &&
                             reg_wdata[`FSPC_READ_BIT] &&
                             reg_wdata[`FSPC_RDEN_BIT] &&
                             reg_wdata[`FSPC_MODE_HI:`FSPC_MODE_LO] ==
                             `FSPC_MODE_READ)
                    begin
                        read_initiate <= 1'b1;
                        flash_read <= 1'b1;
                        flash_word_address <= addr_full;
                        op_count <= 16'h0000;
                        state    <= ST_READ;
                    end
                end
                ST_PROG:
                begin
                    if (sub_tick)
                        op_count <= op_count + 16'h0001;
                    if (sub_tick && op_count == prog_ticks - 16'h0001)
                    begin
                        write_initiate <= 1'b0;
                        flash_erase <= 1'b0;
                        flash_write <= 1'b0;
                        // Page buffer wiped after a write, not after erase
                        if (flash_write)
                        begin
                            buffer_clear_initiate <= 1'b1;
                            clr_addr <= 5'h00;
                            state    <= ST_CLEAR;
                        end
                        else
                            state <= ST_IDLE;
                    end
                end
                ST_READ:
                begin
                    op_count <= op_count + 16'h0001;
                    if (op_count == READ_CYCLES[15:0] - 16'h0001)
                    begin
                        read_word     <= flash_rdata;
                        read_initiate <= 1'b0;
                        flash_read    <= 1'b0;
                        state         <= ST_IDLE;
                    end
                end
                ST_CLEAR:
                begin
                    clr_addr <= clr_addr + 5'h01;
                    if (clr_addr == 5'h1f)
                    begin
                        buffer_clear_initiate <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Read mux; registered so data output comes from a flip-flop
    always @*
    begin
        next_rdata = 8'h00;
        case (reg_addr)
            `FSPC_ADDR_LOW:  next_rdata = addr_low;
            `FSPC_ADDR_HIGH: next_rdata = {2'b00, addr_high};
            `FSPC_W0_LOW:    next_rdata = w0l;
            `FSPC_W0_HIGH:   next_rdata = w0h;
            `FSPC_W1_LOW:    next_rdata = w1l;
            `FSPC_W1_HIGH:   next_rdata = w1h;
            `FSPC_W2_LOW:    next_rdata = w2l;
            `FSPC_W2_HIGH:   next_rdata = w2h;
            `FSPC_W3_LOW:    next_rdata = w3l;
            `FSPC_W3_HIGH:   next_rdata = w3h;
            `FSPC_MAIN_CTRL: next_rdata = {erase_write_enabled_status,
                                           operation_mode_select,
                                           unlock_trigger, write_initiate,
                                           read_enable, read_initiate};
            `FSPC_CHIP_RST:  next_rdata = chip_reset_trigger;
            `FSPC_TIME_BUF:  next_rdata = {6'h00, program_time_select,
                                           buffer_clear_initiate};
            default:         next_rdata = 8'h00;
        endcase
    end

    // Read data registered on a single-cycle read strobe
    always @(posedge ref_clk)
    begin
        if (reset)
            reg_rdata <= 8'h00;
        else if (clk_en && reg_rd)
            reg_rdata <= next_rdata;
    end
endmodule // fspc_ctrl

// file: verilog/fspc_consts.vh
// Register offsets, field positions and timing constants of the flash sequencer
`ifndef FSPC_CONSTS_VH
`define FSPC_CONSTS_VH
// Register offsets on the byte-wide special function register port
`define FSPC_ADDR_LOW      4'h0
`define FSPC_ADDR_HIGH     4'h1
`define FSPC_W0_LOW        4'h2
`define FSPC_W0_HIGH       4'h3
`define FSPC_W1_LOW        4'h4
`define FSPC_W1_HIGH       4'h5
`define FSPC_W2_LOW        4'h6
`define FSPC_W2_HIGH       4'h7
`define FSPC_W3_LOW        4'h8
`define FSPC_W3_HIGH       4'h9
`define FSPC_MAIN_CTRL     4'ha
`define FSPC_CHIP_RST      4'hb
`define FSPC_TIME_BUF      4'hc
// Main control field positions
`define FSPC_EN_BIT        7
`define FSPC_MODE_HI       6
`define FSPC_MODE_LO       4
`define FSPC_UNLOCK_BIT    3
`define FSPC_WRITE_BIT     2
`define FSPC_RDEN_BIT      1
`define FSPC_READ_BIT      0
// Timing and buffer control field positions
`define FSPC_TSEL_BIT      1
`define FSPC_CLR_BIT       0
// Operation mode codes
`define FSPC_MODE_WRITE    3'h0
`define FSPC_MODE_ERASE    3'h1
`define FSPC_MODE_READ     3'h3
`define FSPC_MODE_UNLOCK   3'h6
// Unlock pattern, word1 low to word3 high
`define FSPC_KEY_W1L       8'h00
`define FSPC_KEY_W1H       8'h0d
`define FSPC_KEY_W2L       8'hc3
`define FSPC_KEY_W2H       8'h04
`define FSPC_KEY_W3L       8'h09
`define FSPC_KEY_W3H       8'h40
// Chip reset pattern
`define FSPC_RESET_KEY     8'h55
// Erase/write durations in microseconds, low-speed clock in kHz, then tick, cycle and word counts
`define FSPC_ERASE0_US     3200
`define FSPC_WRITE0_US     2200
`define FSPC_ERASE1_US     3700
`define FSPC_WRITE1_US     3000
`define FSPC_SUB_KHZ       32
`define FSPC_UNLOCK_TICKS  64
`define FSPC_READ_CYCLES   4
`define FSPC_PAGE_WORDS    32
`endif

// file: verilog/fspc_wbuf.v
// Page write buffer: 32 words with registered read and full clear
`timescale 1ns/10ps
module fspc_wbuf #(
    parameter DEPTH = 32,
    parameter AW    = 5,
    parameter DW    = 16
) (
    input  wire          ref_clk,
    input  wire          reset,
    input  wire          clk_en,
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [DW-1:0] wr_data,
    input  wire          clr_en,
    input  wire [AW-1:0] clr_addr,
    input  wire [AW-1:0] rd_addr,
    output reg  [DW-1:0] rd_data
);
    reg [DW-1:0] mem [0:DEPTH-1];

    // Clear walks one word a cycle so the array maps to plain RAM
    always @(posedge ref_clk)
    begin
        if (clk_en)
        begin
            if (clr_en)
                mem[clr_addr] <= {DW{1'b0}};
            else if (wr_en)
                mem[wr_addr] <= wr_data;
        end
    end

    // Registered read port
    always @(posedge ref_clk)
    begin
        if (reset)
            rd_data <= {DW{1'b0}};
        else if (clk_en)
            rd_data <= mem[rd_addr];
    end
endmodule // fspc_wbuf

// file: verilog/fspc_sync.v
// Three-stage synchroniser with agreement-based edge detection
`timescale 1ns/10ps
module fspc_sync (
    input  wire ref_clk,
    input  wire reset,
    input  wire clk_en,
    input  wire async_in,
    output reg  level,
    output wire rise
);
    reg s1;
    reg s2;
    reg s3;

    // s1 feeds only s2; a change counts once s2 and s3 agree
    always @(posedge ref_clk)
    begin
        if (reset)
        begin
            s1    <= 1'b0;
            s2    <= 1'b0;
            s3    <= 1'b0;
            level <= 1'b0;
        end
        else if (clk_en)
        begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
                level <= s3;
        end
    end

    assign rise = clk_en & (s2 == s3) & s3 & ~level;
endmodule // fspc_sync

// file: tb/fspc_ctrl_assertions.sv
// Port-level concurrent checks for the flash self-programming sequencer
`timescale 1ns/10ps
module fspc_ctrl_assertions (
    input wire        ref_clk,
    input wire        reset,
    input wire        clk_en,
    input wire [3:0]  reg_addr,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [7:0]  reg_wdata,
    input wire [7:0]  reg_rdata,
    input wire        core_stall,
    input wire        chip_reset,
    input wire        flash_erase,
    input wire        flash_write,
    input wire        flash_read,
    input wire [13:0] flash_word_address
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    property p_stall; (flash_erase || flash_write || flash_read) |-> core_stall; endproperty
    a_stall: assert property (p_stall) else $error("core not stalled");
    property p_one_op; $onehot0({flash_erase, flash_write, flash_read}); endproperty
    a_one_op: assert property (p_one_op) else $error("two operations");
    property p_rst_pulse; chip_reset |=> !chip_reset; endproperty
    a_rst_pulse: assert property (p_rst_pulse) else $error("long reset");
    property p_rst_cause; clk_en && reg_wr && reg_addr == 4'hb && reg_wdata == 8'h55 |=> chip_reset; endproperty
    a_rst_cause: assert property (p_rst_cause) else $error("no reset");
    property p_rst_only; $rose(chip_reset) |-> $past(reg_wr && reg_addr == 4'hb && reg_wdata == 8'h55); endproperty
    a_rst_only: assert property (p_rst_only) else $error("stray reset");
    property p_high_zero; clk_en && reg_rd && reg_addr == 4'h1 |=> reg_rdata[7:6] == 2'h0; endproperty
    a_high_zero: assert property (p_high_zero) else $error("addr top");
    property p_tb_zero; clk_en && reg_rd && reg_addr == 4'hc |=> reg_rdata[7:2] == 6'h00; endproperty
    a_tb_zero: assert property (p_tb_zero) else $error("unused bits");
    property p_rd_hold; !reg_rd && !chip_reset |=> $stable(reg_rdata); endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
    property p_read_end; $rose(flash_read) |-> ##[1:8] !flash_read; endproperty
    a_read_end: assert property (p_read_end) else $error("read hangs");
    property p_prog_end; $rose(flash_write || flash_erase) |-> ##[1:300] !(flash_write || flash_erase); endproperty
    a_prog_end: assert property (p_prog_end) else $error("op hangs");
    property p_addr_hold; flash_write && $past(flash_write) |-> $stable(flash_word_address); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("addr moved");
endmodule // fspc_ctrl_assertions

bind fspc_ctrl fspc_ctrl_assertions fspc_ctrl_assertions_inst (
    .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .core_stall(core_stall), .chip_reset(chip_reset),
    .flash_erase(flash_erase), .flash_write(flash_write),
    .flash_read(flash_read), .flash_word_address(flash_word_address));

// file: tb/flash_self_program_ctrl_tb.sv
// Register-level test sequence for the flash self-programming sequencer
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked = checked + 1; if ((g) !== (e)) \
    begin fails = fails + 1; $display("unexpected %s exp %h got %h", \
    n, e, g); end end
module flash_self_program_ctrl_tb;
    logic        ref_clk = 1'b0;
    logic        reset = 1'b1;
    logic        clk_en = 1'b1;
    logic        sub_clk = 1'b0;
    logic [2:0]  sub_cnt = 3'h0;
    logic [3:0]  reg_addr = 4'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic [15:0] flash_rdata = 16'h0000;
    logic [4:0]  buf_rd_addr = 5'h00;
    wire  [7:0]  reg_rdata;
    wire         core_stall, chip_reset, flash_erase, flash_write, flash_read;
    wire  [13:0] flash_word_address;
    wire  [15:0] read_word, buf_rd_data;
    logic [47:0] key = 48'h000dc3040940;
    integer      fails = 0, checked = 0, cycles = 0, i, n;

    fspc_ctrl #(.ERASE0_TICKS(6), .WRITE0_TICKS(4), .ERASE1_TICKS(10),
        .WRITE1_TICKS(8), .UNLOCK_TICKS(8)) fspc_ctrl_inst (
        .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .sub_clk(sub_clk),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .core_stall(core_stall), .chip_reset(chip_reset),
        .flash_erase(flash_erase), .flash_write(flash_write),
        .flash_read(flash_read), .flash_word_address(flash_word_address),
        .flash_rdata(flash_rdata), .read_word(read_word),
        .buf_rd_addr(buf_rd_addr), .buf_rd_data(buf_rd_data));

    // 100 ns clock; slow clock is an eighth of it so durations stay short
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        sub_cnt <= sub_cnt + 3'h1;
        sub_clk <= sub_cnt[2];
        cycles = cycles + 1;
        if (cycles == 30000)
        begin
            fails = fails + 1;
            wrap_up;
        end
    end

    task wrap_up;
        begin
            if (fails == 0 && checked > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    // One-cycle strobes; a spare edge between calls avoids double drives
    task wr(input [3:0] a, input [7:0] d);
        begin
            @(posedge ref_clk);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge ref_clk);
            reg_wr <= 1'b0;
            #1;
        end
    endtask

    task rd(input [3:0] a);
        begin
            @(posedge ref_clk);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge ref_clk);
            reg_rd <= 1'b0;
            #1;
        end
    endtask

    task rchk(input [3:0] a, input [7:0] e);
        begin
            rd(a);
            `CHK("register", e, reg_rdata)
        end
    endtask

    // Polls a self-clearing bit under a bounded count of reads
    task poll(input [3:0] a, input [7:0] m);
        begin
            n = 0;
            rd(a);
            while ((reg_rdata & m) !== 8'h00 && n < 400)
            begin
                rd(a);
                n = n + 1;
            end
            `CHK("busy bit", 8'h00, reg_rdata & m)
        end
    endtask

    task bchk(input [4:0] a, input [15:0] e);
        begin
            @(posedge ref_clk);
            buf_rd_addr <= a;
            repeat (2) @(posedge ref_clk);
            #1;
            `CHK("buffer", e, buf_rd_data)
        end
    endtask

    // Starts erase or write and times it in clock cycles
    // A write leaves a buffer clear running, and starts are ignored meanwhile
    task op(input [2:0] m, input t, input integer k);
        begin
            poll(4'hc, 8'h01);
            wr(4'hc, {6'h00, t, 1'b0});
            wr(4'ha, {1'b1, m, 4'h4});
            `CHK("stall", 1'b1, core_stall)
            `CHK("kind", m == 3'h0, flash_write)
            `CHK("erase", m == 3'h1, flash_erase)
            `CHK("address", 14'h001f, flash_word_address)
            n = 0;
            while (core_stall === 1'b1 && n < 400)
            begin
                @(posedge ref_clk);
                #1;
                n = n + 1;
            end
            `CHK("duration", 1'b1, n > k * 8 - 12 && n < k * 8 + 12)
            rchk(4'ha, {1'b1, m, 4'h0});
        end
    endtask

    initial
    begin
        repeat (5) @(posedge ref_clk);
        reset <= 1'b0;
        for (i = 0; i < 13; i = i + 1)
            rchk(i[3:0], 8'h00);
        wr(4'h1, 8'hff);
        rchk(4'h1, 8'h3f);
        wr(4'ha, 8'h80);
        rchk(4'ha, 8'h00);
        for (i = 4; i < 10; i = i + 1)
            wr(i[3:0], 8'h11 * i[7:0]);
        for (i = 4; i < 10; i = i + 1)
            rchk(i[3:0], 8'h11 * i[7:0]);
        wr(4'ha, 8'h68);
        poll(4'ha, 8'h08);
        rchk(4'ha, 8'h60);
        wr(4'ha, 8'h68);
        for (i = 0; i < 6; i = i + 1)
            wr(4'h4 + i[3:0], key[47 - 8 * i -: 8]);
        rchk(4'ha, 8'he8);
        poll(4'ha, 8'h08);
        wr(4'hc, 8'h01);
        poll(4'hc, 8'h01);
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h1e);
        wr(4'ha, 8'h80);
        wr(4'h2, 8'h34);
        bchk(5'h1e, 16'h0000);
        wr(4'h3, 8'h12);
        bchk(5'h1e, 16'h1234);
        rchk(4'h0, 8'h1f);
        wr(4'h2, 8'h78);
        wr(4'h3, 8'h56);
        bchk(5'h1f, 16'h5678);
        rchk(4'h0, 8'h1f);
        wr(4'hc, 8'h01);
        poll(4'hc, 8'h01);
        bchk(5'h1e, 16'h0000);
        wr(4'h3, 8'h9a);
        op(3'h0, 1'b0, 4);
        repeat (40) @(posedge ref_clk);
        bchk(5'h1f, 16'h0000);
        op(3'h1, 1'b0, 6);
        op(3'h0, 1'b1, 8);
        op(3'h1, 1'b1, 10);
        @(posedge ref_clk);
        flash_rdata <= 16'hbeef;
        wr(4'ha, 8'hb3);
        `CHK("read stall", 1'b1, core_stall)
        poll(4'ha, 8'h01);
        `CHK("read word", 16'hbeef, read_word)
        @(posedge ref_clk);
        flash_rdata <= 16'h1111;
        wr(4'ha, 8'hb1);
        `CHK("blocked stall", 1'b0, core_stall)
        rchk(4'ha, 8'hb0);
        `CHK("blocked word", 16'hbeef, read_word)
        wr(4'ha, 8'h00);
        rchk(4'ha, 8'h00);
        wr(4'ha, 8'h04);
        `CHK("locked", 1'b0, core_stall)
        // With the clock enable low a register write must be lost
        @(posedge ref_clk);
        clk_en <= 1'b0;
        wr(4'h5, 8'hab);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        rchk(4'h5, 8'h0d);
        wr(4'hb, 8'h54);
        `CHK("no reset", 1'b0, chip_reset)
        wr(4'hb, 8'h55);
        `CHK("reset", 1'b1, chip_reset)
        repeat (2) @(posedge ref_clk);
        #1;
        `CHK("reset pulse", 1'b0, chip_reset)
        wrap_up;
    end
endmodule // flash_self_program_ctrl_tb
